// >>> hdl/mss_sequencer.sv
// Purpose: Controller-side supply sequencer for a micromirror array device
// Assumes: Sense inputs are synchronous to clk_sys; regulators report power good
// Notes:   Software orders power up and down over a plain strobe port
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module mss_sequencer #(
  parameter int unsigned OFFSET_TO_BIAS_CYC = mss_pkg::OFFSET_TO_BIAS_CYC,
  parameter int unsigned LOGIC_SETTLE_CYC   = mss_pkg::LOGIC_SETTLE_CYC,
  parameter int unsigned DISCHARGE_CYC      = mss_pkg::DISCHARGE_CYC
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  // Command port
  input  wire logic [3:0]        addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output logic      [31:0]       rdata,
  // Supply and mirror side
  input  wire mss_pkg::mss_sense_t sense,
  output mss_pkg::mss_pins_t     pins
);

  mss_pkg::mss_regs_t r_q;
  mss_pkg::mss_regs_t r_d;

  localparam logic [mss_pkg::CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [mss_pkg::CNT_W-1:0] PG_HOLD  =
    mss_pkg::CNT_W'(mss_pkg::PG_HOLD_CYC);

  function automatic logic [mss_pkg::CNT_W-1:0] cyc(input int unsigned n);
    cyc = mss_pkg::CNT_W'(n);
  endfunction : cyc

  function automatic logic done(input logic [mss_pkg::CNT_W-1:0] c);
    done = (c == CNT_ZERO);
  endfunction : done

  always_comb begin
    r_d = r_q;
    if (!done(r_q.cnt)) begin
      r_d.cnt = r_q.cnt - cyc(1);
    end
    r_d.rdata = 32'h0000_0000;
    if (rd_stb) begin
      case (addr)
        mss_pkg::REG_CTRL: begin
          r_d.rdata[mss_pkg::CTRL_UP_BIT]   = r_q.up_req;
          r_d.rdata[mss_pkg::CTRL_DOWN_BIT] = r_q.down_req;
        end
        mss_pkg::REG_STATUS: begin
          r_d.rdata[mss_pkg::STAT_UP_BIT]    = (r_q.st == mss_pkg::MSS_ON);
          r_d.rdata[mss_pkg::STAT_OFF_BIT]   = (r_q.st == mss_pkg::MSS_OFF);
          r_d.rdata[mss_pkg::STAT_EMERG_BIT] = r_q.emerg;
          r_d.rdata[mss_pkg::STAT_FAULT_BIT] = r_q.fault;
          r_d.rdata[mss_pkg::STAT_STATE_LSB +: 10] = r_q.st;
        end
        default: begin
          r_d.rdata = 32'h0000_0000;
        end
      endcase
    end
    case (r_q.st)
      mss_pkg::MSS_OFF: begin
        r_d.pins = '0;
        if (r_q.up_req) begin
          r_d.up_req         = 1'b0;
          r_d.down_req       = 1'b0;
          r_d.emerg          = 1'b0;
          r_d.fault          = 1'b0;
          r_d.pins.logic_en  = 1'b1;
          r_d.cnt            = cyc(LOGIC_SETTLE_CYC);
          r_d.st             = mss_pkg::MSS_LOGIC;
        end
      end
      mss_pkg::MSS_LOGIC: begin
        // Settle time and power good must both be met
        if (done(r_q.cnt) && sense.logic_pg) begin
          r_d.pins.inputs_en = 1'b1;
          r_d.st             = mss_pkg::MSS_WAIT_OE;
        end
      end
      mss_pkg::MSS_WAIT_OE: begin
        if (sense.controller_reset_out_en_n) begin
          r_d.pins.power_down_n = 1'b1;
          r_d.pins.offset_en    = 1'b1;
          r_d.st                = mss_pkg::MSS_OFFSET;
        end
      end
      mss_pkg::MSS_OFFSET: begin
        if (sense.offset_power_good) begin
          r_d.cnt = cyc(OFFSET_TO_BIAS_CYC);
          r_d.st  = mss_pkg::MSS_DELAY;
        end
      end
      mss_pkg::MSS_DELAY: begin
        if (!sense.offset_power_good) begin
          // Offset sagged: the delay must restart from a settled supply
          r_d.st = mss_pkg::MSS_OFFSET;
        end else if (done(r_q.cnt)) begin
          r_d.pins.bias_en   = 1'b1;
          r_d.pins.mreset_en = 1'b1;
          r_d.st             = mss_pkg::MSS_BIAS;
        end
      end
      mss_pkg::MSS_BIAS: begin
        r_d.pins.global_bias = 1'b1;
        r_d.st               = mss_pkg::MSS_ON;
      end
      mss_pkg::MSS_ON: begin
        if (r_q.down_req || sense.power_loss) begin
          r_d.down_req      = 1'b0;
          r_d.emerg         = sense.power_loss;
          r_d.pins.park_req = 1'b1;
          r_d.st            = mss_pkg::MSS_PARK;
        end
      end
      mss_pkg::MSS_PARK: begin
        if (sense.power_loss) begin
          r_d.emerg = 1'b1;
        end
        if (sense.park_done_out_en_n) begin
          r_d.pins.park_req     = 1'b0;
          r_d.pins.global_bias  = 1'b0;
          r_d.pins.power_down_n = 1'b0;
          r_d.pins.bias_en      = 1'b0;
          r_d.pins.mreset_en    = 1'b0;
          r_d.pins.offset_en    = 1'b0;
          r_d.pins.inputs_en    = 1'b0;
          r_d.cnt               = PG_HOLD;
          r_d.st                = mss_pkg::MSS_PG_HOLD;
        end else if (r_q.emerg && !sense.offset_power_good) begin
          // Power good fell before park completed
          r_d.fault = 1'b1;
        end
      end
      mss_pkg::MSS_PG_HOLD: begin
        // Early loss of power good within the hold after an emergency park is tolerated
        if (!done(r_q.cnt) && !sense.offset_power_good && !r_q.emerg) begin
          r_d.fault = 1'b1;
        end
        if (done(r_q.cnt)) begin
          r_d.cnt = cyc(DISCHARGE_CYC);
          r_d.st  = mss_pkg::MSS_DISCH;
        end
      end
      mss_pkg::MSS_DISCH: begin
        if (done(r_q.cnt) && !sense.offset_power_good) begin
          r_d.pins.logic_en = 1'b0;
          r_d.st            = mss_pkg::MSS_OFF;
        end
      end
      default: begin
        r_d.st   = mss_pkg::MSS_OFF;
        r_d.pins = '0;
      end
    endcase
    // Latched after the state logic so a strobe in the consuming cycle is kept
    if (wr_stb && addr == mss_pkg::REG_CTRL) begin
      if (wdata[mss_pkg::CTRL_UP_BIT]) begin
        r_d.up_req = 1'b1;
      end
      if (wdata[mss_pkg::CTRL_DOWN_BIT]) begin
        r_d.down_req = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r_q <= '{st: mss_pkg::MSS_OFF, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  assign rdata = r_q.rdata;
  assign pins  = r_q.pins;

endmodule : mss_sequencer

// >>> hdl/mss_pkg.sv
// Purpose: Shared constants and carriers for the mirror array supply sequencer
// Assumes: 40 MHz system clock
// Notes:   Times are held in their own unit and converted to cycles here
package mss_pkg;

  localparam int unsigned CLK_HZ            = 40_000_000;
  localparam int unsigned CLK_PERIOD_NS     = 25;
  // Offset settled to bias/reset supply enable, minimum and nominal
  localparam int unsigned OFFSET_TO_BIAS_MIN_US = 1000;
  localparam int unsigned OFFSET_TO_BIAS_NOM_US = 2000;
  // Offset power good hold after its enable drops
  localparam int unsigned PG_HOLD_NS        = 100;
  // Settle waits of own choosing for the logic supply and discharge
  localparam int unsigned LOGIC_SETTLE_US   = 100;
  localparam int unsigned DISCHARGE_US      = 1000;

  localparam int unsigned CNT_W = 24;

  // Least times round up to whole cycles
  localparam int unsigned OFFSET_TO_BIAS_CYC =
    (OFFSET_TO_BIAS_NOM_US * (CLK_HZ / 1_000_000));
  localparam int unsigned OFFSET_TO_BIAS_MIN_CYC =
    (OFFSET_TO_BIAS_MIN_US * (CLK_HZ / 1_000_000));
  localparam int unsigned PG_HOLD_CYC =
    (PG_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LOGIC_SETTLE_CYC  = LOGIC_SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DISCHARGE_CYC     = DISCHARGE_US * (CLK_HZ / 1_000_000);

  // Command port register map
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int unsigned CTRL_UP_BIT     = 0;
  localparam int unsigned CTRL_DOWN_BIT   = 1;
  localparam int unsigned STAT_UP_BIT     = 0;
  localparam int unsigned STAT_OFF_BIT    = 1;
  localparam int unsigned STAT_EMERG_BIT  = 2;
  localparam int unsigned STAT_FAULT_BIT  = 3;
  localparam int unsigned STAT_STATE_LSB  = 8;

  typedef enum logic [9:0] {
    MSS_OFF      = 10'h001,
    MSS_LOGIC    = 10'h002,
    MSS_WAIT_OE  = 10'h004,
    MSS_OFFSET   = 10'h008,
    MSS_DELAY    = 10'h010,
    MSS_BIAS     = 10'h020,
    MSS_ON       = 10'h040,
    MSS_PARK     = 10'h080,
    MSS_PG_HOLD  = 10'h100,
    MSS_DISCH    = 10'h200
  } mss_state_t;

  typedef struct packed {
    logic logic_en;
    logic offset_en;
    logic bias_en;
    logic mreset_en;
    logic power_down_n;
    logic inputs_en;
    logic global_bias;
    logic park_req;
  } mss_pins_t;

  typedef struct packed {
    logic logic_pg;
    logic offset_power_good;
    logic controller_reset_out_en_n;
    logic park_done_out_en_n;
    logic power_loss;
  } mss_sense_t;

  typedef struct packed {
    mss_state_t       st;
    logic [CNT_W-1:0] cnt;
    mss_pins_t        pins;
    logic             emerg;
    logic             fault;
    logic             up_req;
    logic             down_req;
    logic [31:0]      rdata;
  } mss_regs_t;

endpackage : mss_pkg

// >>> verif/mss_sequencer_assertions.sv
// Purpose: Port-level checks on the supply sequencer
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound into every sequencer instance
`timescale 1ns/1ps
module mss_sequencer_assertions #(
  parameter int unsigned OFFSET_TO_BIAS_CYC = 20
) (
  // Clock and reset
  input wire logic                clk_sys,
  input wire logic                resetn,
  // Supply and mirror side
  input wire mss_pkg::mss_sense_t sense,
  input wire mss_pkg::mss_pins_t  pins
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_offset_after_logic: assert property (pins.offset_en |->
    pins.logic_en && sense.logic_pg)
    else $error("offset supply enabled before logic supply settled");
  a_bias_after_delay: assert property ($rose(pins.bias_en) |->
    $past(sense.offset_power_good, OFFSET_TO_BIAS_CYC) && sense.offset_power_good)
    else $error("bias supply enabled too early after offset");
  a_bias_reset_pair: assert property (pins.bias_en == pins.mreset_en)
    else $error("bias and mirror reset enables differ");
  a_inputs_need_logic: assert property (pins.inputs_en |->
    pins.logic_en && sense.logic_pg)
    else $error("mirror inputs allowed without logic supply");
  a_park_req_held: assert property (pins.park_req && !sense.park_done_out_en_n |=>
    pins.park_req)
    else $error("park request dropped before park done");
  a_logic_off_last: assert property ($fell(pins.logic_en) |->
    !pins.offset_en && !pins.bias_en && !sense.offset_power_good)
    else $error("logic supply dropped before others discharged");
  a_enable_after_oe: assert property ($rose(pins.offset_en) |->
    $past(sense.controller_reset_out_en_n))
    else $error("supplies enabled before controller ready");
  a_global_after_bias: assert property ($rose(pins.bias_en) |=> pins.global_bias)
    else $error("global bias not raised after supplies up");
  a_park_before_down: assert property ($fell(pins.power_down_n) |->
    $past(sense.park_done_out_en_n) && !pins.bias_en && !pins.offset_en)
    else $error("power down without finished park");

  c_up: cover property ($rose(pins.global_bias));
  c_emerg: cover property ($fell(pins.power_down_n) && sense.power_loss);
  c_off: cover property ($fell(pins.logic_en));
endmodule : mss_sequencer_assertions

bind mss_sequencer mss_sequencer_assertions #(.OFFSET_TO_BIAS_CYC(OFFSET_TO_BIAS_CYC)) chk_i (
  .clk_sys(clk_sys), .resetn(resetn), .sense(sense), .pins(pins));

// >>> verif/mss_supply_model.sv
// Purpose: Regulators, controller ready and mirror park as seen by the sequencer
// Assumes: Power good settles three cycles after an enable
// Notes:   Offset good outlasts its enable by eight cycles, seven on power loss, well over the least hold
`timescale 1ns/1ps
module mss_supply_model (
  // Clock and reset
  input wire logic                clk_sys,
  input wire logic                resetn,
  // Bench controls
  input wire logic                oe_rdy,
  input wire logic                power_loss,
  // Sequencer side
  input wire mss_pkg::mss_pins_t  pins,
  output mss_pkg::mss_sense_t     sense
);
  logic [2:0] lg_q;
  logic [2:0] og_q;
  logic [2:0] pk_q;
  logic [2:0] hold_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lg_q <= 3'h0;
      og_q <= 3'h0;
      pk_q <= 3'h0;
      hold_q <= 3'h0;
    end else begin
      lg_q <= {lg_q[1:0], pins.logic_en};
      pk_q <= {pk_q[1:0], pins.park_req};
      // On power loss offset good falls only once park is reported done
      og_q <= {og_q[1:0], pins.offset_en && !(power_loss && pk_q[2])};
      hold_q <= og_q[2] ? 3'h5 : hold_q - {2'h0, hold_q != 3'h0};
    end
  end
  assign sense = '{logic_pg: lg_q[2], offset_power_good: og_q[2] || hold_q != 3'h0,
                   controller_reset_out_en_n: oe_rdy, park_done_out_en_n: pk_q[2],
                   power_loss: power_loss};
endmodule : mss_supply_model

// >>> verif/mss_sequencer_tb_top.sv
// Purpose: Self-checking bench for the supply sequencer
// Assumes: Short delay parameters so a full cycle runs in a few hundred clocks
// Notes:   States are watched through the status register only
`timescale 1ns/1ps
module mss_sequencer_tb_top;
  logic                clk_sys    = 1'b0;
  logic                resetn     = 1'b0;
  logic [3:0]          addr       = 4'h0;
  logic [31:0]         wdata      = 32'h0;
  logic                wr_stb     = 1'b0;
  logic                rd_stb     = 1'b0;
  logic                oe_rdy     = 1'b0;
  logic                power_loss = 1'b0;
  logic [31:0]         rdata;
  logic [31:0]         d;
  mss_pkg::mss_sense_t sense;
  mss_pkg::mss_pins_t  pins;
  int                  err_total  = 0;
  int                  checked    = 0;

  always #12.5 clk_sys = ~clk_sys;

  mss_sequencer #(.OFFSET_TO_BIAS_CYC(20), .LOGIC_SETTLE_CYC(10), .DISCHARGE_CYC(10)) uut (
    .clk_sys(clk_sys), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .sense(sense), .pins(pins));
  mss_supply_model model (.clk_sys(clk_sys), .resetn(resetn), .oe_rdy(oe_rdy),
    .power_loss(power_loss), .pins(pins), .sense(sense));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic wait_st(input logic [9:0] st);
    for (int i = 0; i < 400; i++) begin
      rd(mss_pkg::REG_STATUS);
      if (d[17:8] === st) return;
    end
    chk("state wait", d[17:8], {22'h0, st});
    complete_run();
  endtask : wait_st

  // Pins are sampled at the falling edge, clear of the edge that launches them
  task automatic wait_logic_off;
    for (int i = 0; i < 400; i++) begin
      @(negedge clk_sys);
      if (pins.logic_en === 1'b0) return;
    end
    chk("logic off wait", {31'h0, pins.logic_en}, 32'h0);
    complete_run();
  endtask : wait_logic_off

  initial begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    chk("reset pins", {24'h0, pins}, 32'h0);
    rd(4'h8);
    chk("unmapped read", d, 32'h0);
    rd(mss_pkg::REG_STATUS);
    chk("off status", {d[17:8], d[1]}, {mss_pkg::MSS_OFF, 1'b1});
    $display("test reset done");
    wr(mss_pkg::REG_CTRL, 32'h2);
    wr(mss_pkg::REG_CTRL, 32'h1);
    wait_st(mss_pkg::MSS_WAIT_OE);
    repeat (30) @(posedge clk_sys);
    chk("offset_en held", {31'h0, pins.offset_en}, 32'h0);
    chk("inputs_en", {31'h0, pins.inputs_en}, 32'h1);
    oe_rdy <= 1'b1;
    wait_st(mss_pkg::MSS_ON);
    chk("on pins", {24'h0, pins}, 32'hfe);
    wr(mss_pkg::REG_CTRL, 32'h1);
    rd(mss_pkg::REG_CTRL);
    chk("up held in on", d, 32'h1);
    rd(mss_pkg::REG_STATUS);
    chk("up in on", {d[17:8], d[0]}, {mss_pkg::MSS_ON, 1'b1});
    $display("test power up done");
    // The up request written while on stays latched, so off lasts one cycle
    wr(mss_pkg::REG_CTRL, 32'h2);
    wait_logic_off();
    chk("off pins", {24'h0, pins}, 32'h0);
    $display("test power down done");
    wait_st(mss_pkg::MSS_ON);
    power_loss <= 1'b1;
    wait_st(mss_pkg::MSS_OFF);
    chk("emergency fault", {31'h0, d[3]}, 32'h0);
    chk("emergency flag", {31'h0, d[2]}, 32'h1);
    chk("emergency pins", {pins.logic_en, pins.offset_en, pins.bias_en}, 3'h0);
    power_loss <= 1'b0;
    $display("test emergency park done");
    complete_run();
  end
endmodule : mss_sequencer_tb_top
